// ### dv/uoia_host_model.sv
`timescale 1ns/10ps
`include "uoia_defines.svh"
// ==========================================
// host processor: bus master and software sequences
module uoia_host_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic hang
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		hang = 1'b0;
	end

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64) hang <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a);
		xfer(1'b0, a, 32'h0000_0000);
	endtask : rd

	// open latch, clear top status, close latch
	task automatic silence(input logic [31:0] cfg);
		wr(`UOIA_A_HOST_CFG, cfg | 32'h0000_0001);
		wr(`UOIA_A_TOP_CLEAR, 32'h0000_03ff);
		wr(`UOIA_A_HOST_CFG, cfg & 32'hffff_fffe);
	endtask : silence

	// open latch, drop top enables, close latch; status is kept
	task automatic mask(input logic [31:0] cfg);
		wr(`UOIA_A_HOST_CFG, cfg | 32'h0000_0001);
		wr(`UOIA_A_TOP_ENABLE, 32'h0000_0000);
		wr(`UOIA_A_HOST_CFG, cfg & 32'hffff_fffe);
	endtask : mask

	// both sources set alike before sharing one pin
	task automatic merge(input logic pol, input logic edg);
		wr(`UOIA_A_PERIPH_CFG, {30'h0, edg, pol});
		wr(`UOIA_A_HOST_CFG, {22'h0, 1'b1, 6'h0, edg, pol, 1'b1});
	endtask : merge
endmodule : uoia_host_model

// ### dv/uoia_top_bench.sv
`timescale 1ns/10ps
`include "uoia_defines.svh"
module uoia_top_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pri, sec, hang;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [5:0] op_event;
	logic [10:0] dr_event;
	logic [9:0] top_event;
	logic [7:0] periph_event;
	logic [32:0] exp_q[$];
	string nm_q[$];
	int n_fail, total_checks, k, j, n;

	uoia_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .op_event(op_event), .dr_event(dr_event), .top_event(top_event),
		.periph_event(periph_event), .irq_pin_primary(pri), .irq_pin_secondary(sec));
	uoia_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hang(hang));

	// ==========================================
	// checking and reporting
	task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] e);
		total_checks++;
		if (seen !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, seen);
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	task automatic rd_exp(input string nm, input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		nm_q.push_back(nm);
		host.rd(a);
	endtask : rd_exp

	// waits up to dl cycles for the pin level, then compares
	task automatic pin(input string nm, input logic s, input logic e, input int dl);
		int c;
		c = 0;
		while (c < dl && ((s ? sec : pri) !== e)) begin
			@(posedge pclk);
			c++;
		end
		check(nm, {32'h0, (s ? sec : pri)}, {32'h0, e});
	endtask : pin

	task automatic evs(input logic [5:0] o, input logic [10:0] d, input logic [9:0] t,
		input logic [7:0] p);
		@(posedge pclk);
		op_event <= o;
		dr_event <= d;
		top_event <= t;
		periph_event <= p;
		repeat (2) @(posedge pclk);
		{op_event, dr_event, top_event, periph_event} <= '0;
	endtask : evs

	always @(posedge pclk)
		if (psel && penable && pready && !pwrite && exp_q.size() > 0)
			check(nm_q.pop_front(), {pslverr, prdata}, exp_q.pop_front());

	always @(posedge hang) begin
		n_fail++;
		summarize();
	end

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		summarize();
	end

	// ==========================================
	// scenarios
	initial begin
		presetn = 1'b0;
		{op_event, dr_event, top_event, periph_event} = '0;
		void'($urandom(32'ha618));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		pin("pri_rst", 1'b0, 1'b1, 0);
		pin("sec_rst", 1'b1, 1'b1, 0);
		rd_exp("host_cfg_rst", `UOIA_A_HOST_CFG, 33'h0);
		rd_exp("unmapped", 12'h030, {1'b1, 32'h0});
		$display("test reset done");
		k = $urandom_range(5, 0);
		host.wr(`UOIA_A_OP_ENABLE, 32'h1 << k);
		host.wr(`UOIA_A_TOP_ENABLE, 32'h0000_03ff);
		host.wr(`UOIA_A_HOST_CFG, 32'h0000_0001);
		evs(6'h1 << k, 11'h0, 10'h0, 8'h0);
		repeat (8) @(posedge pclk);
		rd_exp("op_status", `UOIA_A_OP_STATUS, {1'b0, 32'h1 << k});
		rd_exp("top_no_mie", `UOIA_A_TOP_STATUS, 33'h0);
		pin("pri_no_mie", 1'b0, 1'b1, 0);
		host.wr(`UOIA_A_OP_ENABLE, 32'h8000_0000 | (32'h1 << k));
		pin("pri_op", 1'b0, 1'b0, 30);
		rd_exp("top_op", `UOIA_A_TOP_STATUS, 33'h1);
		host.wr(`UOIA_A_OP_ENABLE, 32'h0000_0000);
		rd_exp("op_sticky", `UOIA_A_OP_STATUS, {1'b0, 32'h1 << k});
		pin("pri_level", 1'b0, 1'b0, 0);
		$display("test operational group done");
		host.wr(`UOIA_A_OP_STATUS, 32'h0000_003f);
		host.silence(32'h0);
		pin("pri_silenced", 1'b0, 1'b1, 30);
		j = $urandom_range(10, 0);
		host.wr(`UOIA_A_DR_ENABLE, 32'h0000_07ff);
		evs(6'h0, 11'h1 << j, 10'h0, 8'h0);
		repeat (12) @(posedge pclk);
		pin("pri_held", 1'b0, 1'b1, 0);
		rd_exp("top_dr", `UOIA_A_TOP_STATUS, {1'b0, 32'h200});
		host.wr(`UOIA_A_HOST_CFG, 32'h0000_0001);
		pin("pri_dr", 1'b0, 1'b0, 30);
		host.mask(32'h0);
		pin("pri_masked", 1'b0, 1'b1, 30);
		j = $urandom_range(8, 1);
		evs(6'h0, 11'h0, 10'h1 << j, 8'h0);
		repeat (8) @(posedge pclk);
		rd_exp("top_ev", `UOIA_A_TOP_STATUS, {1'b0, 32'h200 | (32'h1 << j)});
		pin("pri_masked_hold", 1'b0, 1'b1, 0);
		host.wr(`UOIA_A_TOP_ENABLE, 32'h0000_03ff);
		repeat (4) @(posedge pclk);
		pin("pri_closed_hold", 1'b0, 1'b1, 0);
		host.wr(`UOIA_A_HOST_CFG, 32'h0000_0001);
		pin("pri_reenabled", 1'b0, 1'b0, 30);
		host.wr(`UOIA_A_DR_STATUS, 32'h0000_07ff);
		host.silence(32'h0);
		pin("pri_cleared", 1'b0, 1'b1, 30);
		$display("test latch and mask done");
		j = $urandom_range(7, 0);
		host.wr(`UOIA_A_PERIPH_EN, 32'h0000_00ff);
		evs(6'h0, 11'h0, 10'h0, 8'h1 << j);
		repeat (12) @(posedge pclk);
		pin("sec_no_gie", 1'b1, 1'b1, 0);
		host.wr(`UOIA_A_PERIPH_MODE, 32'h0000_0008);
		pin("sec_level", 1'b1, 1'b0, 30);
		host.wr(`UOIA_A_PERIPH_CFG, 32'h0000_0001);
		pin("sec_pol", 1'b1, 1'b1, 30);
		host.merge(1'b0, 1'b0);
		pin("pri_merged", 1'b0, 1'b0, 30);
		pin("sec_merged", 1'b1, 1'b1, 30);
		host.wr(`UOIA_A_HOST_CFG, 32'h0000_0001);
		host.wr(`UOIA_A_PERIPH_STATUS, 32'h0000_00ff);
		host.wr(`UOIA_A_PERIPH_CFG, 32'h0000_0002);
		pin("sec_idle", 1'b1, 1'b1, 30);
		evs(6'h0, 11'h0, 10'h0, 8'h1 << j);
		n = 0;
		repeat (48) begin
			@(posedge pclk);
			if (sec === 1'b0) n++;
		end
		check("pulse_len", {1'b0, 32'(n)}, {1'b0, 32'(`UOIA_PULSE_CYC)});
		rd_exp("periph_kept", `UOIA_A_PERIPH_STATUS, {1'b0, 32'h1 << j});
		$display("test peripheral path done");
		repeat (2) @(posedge pclk);
		summarize();
	end
endmodule : uoia_top_bench

// ### logic/uoia_defines.svh
`ifndef UOIA_DEFINES_SVH
`define UOIA_DEFINES_SVH
// register byte addresses
`define UOIA_A_OP_STATUS 12'h000
`define UOIA_A_OP_ENABLE 12'h004
`define UOIA_A_DR_STATUS 12'h008
`define UOIA_A_DR_ENABLE 12'h00c
`define UOIA_A_TOP_STATUS 12'h010
`define UOIA_A_TOP_ENABLE 12'h014
`define UOIA_A_HOST_CFG 12'h018
`define UOIA_A_PERIPH_MODE 12'h01c
`define UOIA_A_PERIPH_CFG 12'h020
`define UOIA_A_PERIPH_EN 12'h024
`define UOIA_A_PERIPH_STATUS 12'h028
`define UOIA_A_TOP_CLEAR 12'h02c
// field widths and positions
`define UOIA_OP_N 6
`define UOIA_DR_N 11
`define UOIA_TOP_N 10
`define UOIA_PER_N 8
`define UOIA_MIE_BIT 31
`define UOIA_TOP_OP_BIT 0
`define UOIA_TOP_DR_BIT 9
`define UOIA_HC_PIN_EN_BIT 0
`define UOIA_HC_POL_BIT 1
`define UOIA_HC_EDGE_BIT 2
`define UOIA_HC_ONE_BIT 9
`define UOIA_DC_POL_BIT 0
`define UOIA_DC_EDGE_BIT 1
`define UOIA_DC_GIE_BIT 3
// reset values: level triggered, active low, pin latch closed
`define UOIA_HOST_CFG_RST 32'h0000_0000
`define UOIA_PERIPH_CFG_RST 32'h0000_0000
// edge pulse width
`define UOIA_PULSE_NS 160
`define UOIA_CLK_MHZ 125
`define UOIA_PULSE_CYC ((`UOIA_PULSE_NS * `UOIA_CLK_MHZ) / 1000)
`endif

// ### logic/uoia_pkg.sv
package uoia_pkg;
	typedef enum logic [0:0] {
		UOIA_LEVEL = 1'b0,
		UOIA_EDGE = 1'b1
	} uoia_trig_e;
	typedef logic [4:0] uoia_cnt_t;
endpackage : uoia_pkg

// ### logic/uoia_top.sv
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
// Function
// - the host operational group holds six sticky event flags set by their events.
// - the enabled operational flags are ORed, gated by master enable bit 31, and set the summary top bit.
// - the dual-role group holds eleven flags whose enabled OR sets the dual-role top bit, no master enable.
// - the top status holds ten flags, eight events on bits 1 to 8 and the two group summaries on bits 0 and 9, each qualified by its own top enable bit.
// - the OR of enabled top flags reaches the primary pin through a latch opened by host config bit 0.
// - while the pin latch enable is zero the latched host request holds its level whatever status and enable registers do.
// - peripheral mode bit 3 is the global enable of peripheral interrupts.
// - peripheral config bit 1 selects edge trigger and bit 0 the output polarity.
// - by default host and dual-role go to the primary pin and peripheral to the secondary pin.
// - host config bit 9 merges the peripheral interrupt onto the primary pin.
// - in level mode the output stays asserted while an enabled pending event remains.
// - in edge mode a pulse of about 160 ns is sent, the event staying readable in top status or peripheral status.
// - host config bits 1 and 2 set host polarity and trigger, reset to level and active low.
`include "uoia_defines.svh"
module uoia_top import uoia_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`UOIA_OP_N-1:0] op_event,
	input wire logic [`UOIA_DR_N-1:0] dr_event,
	input wire logic [`UOIA_TOP_N-1:0] top_event,
	input wire logic [`UOIA_PER_N-1:0] periph_event,
	output logic irq_pin_primary,
	output logic irq_pin_secondary
);
	localparam uoia_cnt_t PULSE_CYC = uoia_cnt_t'(`UOIA_PULSE_CYC);
	// ==========================================================
	// event input synchronisers
	// ==========================================================
	localparam int EW = `UOIA_OP_N + `UOIA_DR_N + `UOIA_TOP_N + `UOIA_PER_N;
	logic [EW-1:0] ev_meta;
	logic [EW-1:0] ev_sync;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_meta <= '0;
			ev_sync <= '0;
		end else begin
			ev_meta <= {periph_event, top_event, dr_event, op_event};
			ev_sync <= ev_meta;
		end
	end
	logic [`UOIA_OP_N-1:0] op_ev;
	logic [`UOIA_DR_N-1:0] dr_ev;
	logic [`UOIA_TOP_N-1:0] top_ev;
	logic [`UOIA_PER_N-1:0] per_ev;
	assign op_ev = ev_sync[`UOIA_OP_N-1:0];
	assign dr_ev = ev_sync[`UOIA_OP_N+`UOIA_DR_N-1:`UOIA_OP_N];
	assign top_ev = ev_sync[`UOIA_OP_N+`UOIA_DR_N+`UOIA_TOP_N-1:`UOIA_OP_N+`UOIA_DR_N];
	assign per_ev = ev_sync[EW-1:EW-`UOIA_PER_N];
	// ==========================================================
	// apb decode
	// ==========================================================
	logic wr_acc;
	logic rd_acc;
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
		hit = (a == r);
	endfunction : hit
	logic mapped;
	assign mapped = (paddr <= `UOIA_A_TOP_CLEAR) && (paddr[1:0] == 2'b00);
	// ==========================================================
	// configuration registers
	// ==========================================================
	logic [`UOIA_OP_N-1:0] host_op_event_enable;
	logic master_irq_enable;
	logic [`UOIA_DR_N-1:0] dual_role_event_enable;
	logic [`UOIA_TOP_N-1:0] top_level_irq_enable;
	logic [31:0] host_hw_config;
	logic [31:0] periph_mode_reg;
	logic [31:0] periph_hw_config;
	logic [`UOIA_PER_N-1:0] periph_irq_enable;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_op_event_enable <= '0;
			master_irq_enable <= 1'b0;
			dual_role_event_enable <= '0;
			top_level_irq_enable <= '0;
			host_hw_config <= `UOIA_HOST_CFG_RST;
			periph_mode_reg <= '0;
			periph_hw_config <= `UOIA_PERIPH_CFG_RST;
			periph_irq_enable <= '0;
		end else if (wr_acc) begin
			if (hit(paddr, `UOIA_A_OP_ENABLE)) begin
				host_op_event_enable <= pwdata[`UOIA_OP_N-1:0];
				master_irq_enable <= pwdata[`UOIA_MIE_BIT];
			end
			if (hit(paddr, `UOIA_A_DR_ENABLE))
				dual_role_event_enable <= pwdata[`UOIA_DR_N-1:0];
			if (hit(paddr, `UOIA_A_TOP_ENABLE))
				top_level_irq_enable <= pwdata[`UOIA_TOP_N-1:0];
			if (hit(paddr, `UOIA_A_HOST_CFG))
				host_hw_config <= pwdata;
			if (hit(paddr, `UOIA_A_PERIPH_MODE))
				periph_mode_reg <= pwdata;
			if (hit(paddr, `UOIA_A_PERIPH_CFG))
				periph_hw_config <= pwdata;
			if (hit(paddr, `UOIA_A_PERIPH_EN))
				periph_irq_enable <= pwdata[`UOIA_PER_N-1:0];
		end
	end
	// ==========================================================
	// sticky status: set wins over write-one-to-clear
	// ==========================================================
	logic [`UOIA_OP_N-1:0] host_op_event_status;
	logic [`UOIA_DR_N-1:0] dual_role_event_status;
	logic [`UOIA_TOP_N-1:0] top_level_irq_status;
	logic [`UOIA_PER_N-1:0] periph_irq_status;
	logic op_group_summary;
	logic dual_role_summary;
	assign op_group_summary = |(host_op_event_status & host_op_event_enable)
		&& master_irq_enable;
	assign dual_role_summary = |(dual_role_event_status & dual_role_event_enable);
	logic [`UOIA_TOP_N-1:0] top_set;
	always_comb begin
		top_set = top_ev;
		top_set[`UOIA_TOP_OP_BIT] = op_group_summary;
		top_set[`UOIA_TOP_DR_BIT] = dual_role_summary;
	end
	logic [`UOIA_OP_N-1:0] op_clr;
	logic [`UOIA_DR_N-1:0] dr_clr;
	logic [`UOIA_TOP_N-1:0] top_clr;
	logic [`UOIA_PER_N-1:0] per_clr;
	assign op_clr = (wr_acc && hit(paddr, `UOIA_A_OP_STATUS)) ? pwdata[`UOIA_OP_N-1:0] : '0;
	assign dr_clr = (wr_acc && hit(paddr, `UOIA_A_DR_STATUS)) ? pwdata[`UOIA_DR_N-1:0] : '0;
	assign top_clr = (wr_acc && (hit(paddr, `UOIA_A_TOP_STATUS) || hit(paddr, `UOIA_A_TOP_CLEAR)))
		? pwdata[`UOIA_TOP_N-1:0] : '0;
	assign per_clr = (wr_acc && hit(paddr, `UOIA_A_PERIPH_STATUS))
		? pwdata[`UOIA_PER_N-1:0] : '0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_op_event_status <= '0;
			dual_role_event_status <= '0;
			top_level_irq_status <= '0;
			periph_irq_status <= '0;
		end else begin
			host_op_event_status <= (host_op_event_status & ~op_clr) | op_ev;
			dual_role_event_status <= (dual_role_event_status & ~dr_clr) | dr_ev;
			top_level_irq_status <= (top_level_irq_status & ~top_clr) | top_set;
			periph_irq_status <= (periph_irq_status & ~per_clr) | per_ev;
		end
	end
	// ==========================================================
	// pin latch, trigger shaping and routing
	// ==========================================================
	logic host_req;
	logic per_req;
	assign host_req = |(top_level_irq_status & top_level_irq_enable);
	assign per_req = |(periph_irq_status & periph_irq_enable)
		&& periph_mode_reg[`UOIA_DC_GIE_BIT];
	logic host_latched;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			host_latched <= 1'b0;
		else if (host_hw_config[`UOIA_HC_PIN_EN_BIT])
			host_latched <= host_req;
	end
	logic host_prev;
	logic per_prev;
	uoia_cnt_t host_cnt;
	uoia_cnt_t per_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_prev <= 1'b0;
			per_prev <= 1'b0;
			host_cnt <= '0;
			per_cnt <= '0;
		end else begin
			host_prev <= host_latched;
			per_prev <= per_req;
			if (host_latched && !host_prev)
				host_cnt <= PULSE_CYC;
			else if (host_cnt != '0)
				host_cnt <= host_cnt - 5'd1;
			if (per_req && !per_prev)
				per_cnt <= PULSE_CYC;
			else if (per_cnt != '0)
				per_cnt <= per_cnt - 5'd1;
		end
	end
	logic host_act;
	logic per_act;
	uoia_trig_e host_trig;
	uoia_trig_e per_trig;
	assign host_trig = uoia_trig_e'(host_hw_config[`UOIA_HC_EDGE_BIT]);
	assign per_trig = uoia_trig_e'(periph_hw_config[`UOIA_DC_EDGE_BIT]);
	assign host_act = (host_trig == UOIA_EDGE) ? (host_cnt != '0) : host_latched;
	assign per_act = (per_trig == UOIA_EDGE) ? (per_cnt != '0) : per_req;
	logic host_pin;
	logic per_pin;
	logic merge;
	assign merge = host_hw_config[`UOIA_HC_ONE_BIT];
	// merged case uses host polarity; both are assumed equal
	assign host_pin = (host_act || (merge && per_act)) ~^ host_hw_config[`UOIA_HC_POL_BIT]
		? 1'b1 : 1'b0;
	assign per_pin = (per_act && !merge) ~^ periph_hw_config[`UOIA_DC_POL_BIT] ? 1'b1 : 1'b0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pin_primary <= 1'b1;
			irq_pin_secondary <= 1'b1;
		end else begin
			irq_pin_primary <= host_pin;
			irq_pin_secondary <= per_pin;
		end
	end
	// ==========================================================
	// apb read
	// ==========================================================
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (paddr)
			`UOIA_A_OP_STATUS: rd_mux[`UOIA_OP_N-1:0] = host_op_event_status;
			`UOIA_A_OP_ENABLE: begin
				rd_mux[`UOIA_OP_N-1:0] = host_op_event_enable;
				rd_mux[`UOIA_MIE_BIT] = master_irq_enable;
			end
			`UOIA_A_DR_STATUS: rd_mux[`UOIA_DR_N-1:0] = dual_role_event_status;
			`UOIA_A_DR_ENABLE: rd_mux[`UOIA_DR_N-1:0] = dual_role_event_enable;
			`UOIA_A_TOP_STATUS: rd_mux[`UOIA_TOP_N-1:0] = top_level_irq_status;
			`UOIA_A_TOP_ENABLE: rd_mux[`UOIA_TOP_N-1:0] = top_level_irq_enable;
			`UOIA_A_HOST_CFG: rd_mux = host_hw_config;
			`UOIA_A_PERIPH_MODE: rd_mux = periph_mode_reg;
			`UOIA_A_PERIPH_CFG: rd_mux = periph_hw_config;
			`UOIA_A_PERIPH_EN: rd_mux[`UOIA_PER_N-1:0] = periph_irq_enable;
			`UOIA_A_PERIPH_STATUS: rd_mux[`UOIA_PER_N-1:0] = periph_irq_status;
			default: rd_mux = '0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && !pwrite) ? rd_mux : '0;
		end
	end
	// ==========================================================
	// assertions
	// ==========================================================
	sequence s_latch_closed;
		!host_hw_config[`UOIA_HC_PIN_EN_BIT] && $past(!host_hw_config[`UOIA_HC_PIN_EN_BIT]);
	endsequence
	a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
		s_latch_closed |-> $stable(host_latched))
		else $error("pin latch changed while closed");
	a_latch_follow: assert property (@(posedge pclk) disable iff (!presetn)
		host_hw_config[`UOIA_HC_PIN_EN_BIT] |=> host_latched == $past(host_req))
		else $error("pin latch did not follow request");
	a_op_summary: assert property (@(posedge pclk) disable iff (!presetn)
		op_group_summary |=> top_level_irq_status[`UOIA_TOP_OP_BIT])
		else $error("operational summary not recorded");
	a_op_mie_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!master_irq_enable && !top_level_irq_status[`UOIA_TOP_OP_BIT]
		|=> !top_level_irq_status[`UOIA_TOP_OP_BIT])
		else $error("summary set without master enable");
	a_dr_summary: assert property (@(posedge pclk) disable iff (!presetn)
		dual_role_summary |=> top_level_irq_status[`UOIA_TOP_DR_BIT])
		else $error("dual role summary not recorded");
	a_op_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		op_ev[0] |=> host_op_event_status[0])
		else $error("operational event lost");
	a_top_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		top_level_irq_status[1] && top_clr[1] == 1'b0 |=> top_level_irq_status[1])
		else $error("top flag dropped without clear");
	a_per_gie: assert property (@(posedge pclk) disable iff (!presetn)
		!periph_mode_reg[`UOIA_DC_GIE_BIT] && !periph_hw_config[`UOIA_DC_EDGE_BIT] && !merge
		|=> irq_pin_secondary == !$past(periph_hw_config[`UOIA_DC_POL_BIT]))
		else $error("peripheral request without global enable");
	a_edge_width: assert property (@(posedge pclk) disable iff (!presetn)
		host_latched && !host_prev |=> (host_cnt != '0)[*8] ##1 (host_cnt != '0)[*8]
		##1 (host_cnt != '0)[*4] ##1 host_cnt == '0)
		else $error("edge pulse width wrong");
	a_merge_route: assert property (@(posedge pclk) disable iff (!presetn)
		merge && per_act |=> irq_pin_primary == $past(host_hw_config[`UOIA_HC_POL_BIT]))
		else $error("merged peripheral request not on primary pin");
endmodule : uoia_top
